// File: include/ccs_pkg.sv
/*
  package for the chain conversion sequencer: register offsets, control
  field positions, reset values, acquisition and conversion timing, and the
  sample and result carriers.
  assumes a 25 MHz clock and a 32-bit Avalon-MM register port.
*/
package ccs_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned ACQ_STEP_NS    = 400;
  localparam int unsigned CONV_NS        = 600;
  localparam int unsigned HOP_DELAY_NS   = 200;
  localparam int unsigned ACQ_STEP_CYC   = (ACQ_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC       = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOP_CYC        = (HOP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_PARTS      = 50;
  localparam int unsigned NUM_VOLT       = 6;
  localparam int unsigned NUM_TEMP       = 6;
  localparam int unsigned NUM_CH         = 13;
  localparam int unsigned SELFTEST_CH    = 12;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_ALERT    = 8'h04;
  localparam logic [7:0] OFS_COMMAND  = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_ADC      = 8'h10;
  localparam logic [7:0] OFS_RESULT0  = 8'h40;
  localparam logic [7:0] OFS_RESULT_END = 8'h70;

  // control fields
  localparam int unsigned CTL_SEL_HI   = 15;
  localparam int unsigned CTL_SEL_LO   = 14;
  localparam int unsigned CTL_RB_HI    = 13;
  localparam int unsigned CTL_RB_LO    = 12;
  localparam int unsigned CTL_AVG_HI   = 10;
  localparam int unsigned CTL_AVG_LO   = 9;
  localparam int unsigned CTL_ACQ_HI   = 6;
  localparam int unsigned CTL_ACQ_LO   = 5;
  localparam int unsigned CTL_TERM     = 3;
  localparam logic [15:0] CONTROL_RST  = 16'h0000;
  localparam logic [1:0]  ALERT_RST    = 2'h0;

  // command bits
  localparam int unsigned CMD_START    = 0;
  localparam int unsigned CMD_ALL      = 1;

  // selection codes
  localparam logic [1:0] SEL_ALL      = 2'h0;
  localparam logic [1:0] SEL_ODD      = 2'h1;
  localparam logic [1:0] SEL_VOLT     = 2'h2;
  localparam logic [1:0] SEL_SELFTEST = 2'h3;

  typedef struct packed {
    logic [3:0]  chan;
    logic [11:0] data;
  } ccs_sample_s;

  typedef struct packed {
    logic [3:0]  chan;
    logic [11:0] data;
    logic        alert_en;
  } ccs_result_s;

endpackage

// File: verilog/ccs_sequencer.sv
/*
  chain conversion sequencer: takes a start from the pin or chip select,
  relays it up the chain after one hop delay, walks the selected channels
  with acquisition and conversion phases, averages repeats and stores
  results, then hands each to the alert path unless alert_cfg masks it (channel 8 or 10).
  assumes synchronous inputs, a 12-bit converter answering adc_valid_i
  within the conversion slot, and an Avalon-MM master.
*/
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps

module ccs_sequencer (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 conversion_start_pin_n_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 chain_start_i,
  output logic                      chain_start_o,
  output logic                      adc_start_o,
  output logic [3:0]                adc_chan_o,
  output logic                      adc_bandgap_o,
  input  wire logic                 adc_valid_i,
  input  wire logic [11:0]          adc_data_i,
  output logic                      thermistor_termination_en_o,
  output ccs_pkg::ccs_result_s      result_o,
  output logic                      result_valid_o,
  output logic                      busy_o,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [6:0] acq_cycles(input logic [1:0] code);
    acq_cycles = 7'((32'(code) + 32'd1) * ccs_pkg::ACQ_STEP_CYC);
  endfunction

  function automatic logic channel_selected(input logic [1:0] sel, input logic [3:0] ch);
    unique case (sel)
      ccs_pkg::SEL_ALL:      channel_selected = (ch < 4'hC);
      ccs_pkg::SEL_ODD:      channel_selected = (ch < 4'h6) || (ch == 4'h6) ||
                                                (ch == 4'h8) || (ch == 4'hA);
      ccs_pkg::SEL_VOLT:     channel_selected = (ch < 4'h6);
      ccs_pkg::SEL_SELFTEST: channel_selected = (ch == 4'hC);
    endcase
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] control, next_control;
  logic [1:0]  alert_cfg, next_alert_cfg;
  logic [11:0] results [ccs_pkg::NUM_CH];
  logic [11:0] next_results [ccs_pkg::NUM_CH];
  logic        cs_prev, next_cs_prev;
  logic        pin_prev, next_pin_prev;
  logic        rd_ack, next_rd_ack;
  logic [31:0] rdata, next_rdata;
  logic        sw_start, self_all;

  wire logic [1:0] sel_f = control[ccs_pkg::CTL_SEL_HI:ccs_pkg::CTL_SEL_LO];
  wire logic [1:0] avg_f = control[ccs_pkg::CTL_AVG_HI:ccs_pkg::CTL_AVG_LO];
  wire logic [1:0] acq_f = control[ccs_pkg::CTL_ACQ_HI:ccs_pkg::CTL_ACQ_LO];

  always_comb begin
    next_control   = control;
    next_alert_cfg = alert_cfg;
    next_rd_ack    = 1'b0;
    next_rdata     = rdata;
    sw_start       = 1'b0;
    self_all       = 1'b0;
    if (avs_write) begin
      unique case (avs_address)
        ccs_pkg::OFS_CONTROL: next_control   = avs_writedata[15:0];
        ccs_pkg::OFS_ALERT:   next_alert_cfg = avs_writedata[1:0];
        ccs_pkg::OFS_COMMAND: begin
          sw_start = avs_writedata[ccs_pkg::CMD_START];
          self_all = avs_writedata[ccs_pkg::CMD_ALL];
        end
        default: ;
      endcase
    end
    if (avs_read && !rd_ack) begin
      next_rd_ack = 1'b1;
      next_rdata  = 32'h0000_0000;
      if (avs_address == ccs_pkg::OFS_CONTROL) begin
        next_rdata = {16'h0000, control};
      end else if (avs_address == ccs_pkg::OFS_ALERT) begin
        next_rdata = {30'h0000_0000, alert_cfg};
      end else if (avs_address == ccs_pkg::OFS_STATUS) begin
        next_rdata = {31'h0000_0000, busy_o};
      end else if (avs_address >= ccs_pkg::OFS_RESULT0 &&
                   avs_address <= ccs_pkg::OFS_RESULT_END) begin
        next_rdata = {20'h0_0000, results[4'(avs_address[5:2])]};
      end
    end
  end

  assign avs_waitrequest = avs_read && !rd_ack;
  assign avs_readdata    = rdata;
  assign thermistor_termination_en_o = control[ccs_pkg::CTL_TERM];

  // ****************************************************************
  // start detection and chain relay
  // ****************************************************************
  logic        start_evt;
  logic        relay_evt;
  logic [2:0]  hop_cnt, next_hop_cnt;
  logic        hop_run, next_hop_run;

  assign next_cs_prev  = cs_n_i;
  assign next_pin_prev = conversion_start_pin_n_i;
  // a software start stays local unless the all-devices flag goes with it
  assign relay_evt = (!cs_prev && cs_n_i) || (pin_prev && !conversion_start_pin_n_i) ||
                     chain_start_i || (sw_start && self_all);
  assign start_evt = relay_evt || sw_start;

  always_comb begin
    next_hop_cnt = hop_cnt;
    next_hop_run = hop_run;
    if (relay_evt) begin
      next_hop_run = 1'b1;
      next_hop_cnt = 3'(ccs_pkg::HOP_CYC);
    end else if (hop_run) begin
      next_hop_cnt = hop_cnt - 3'h1;
      if (hop_cnt == 3'h1) begin
        next_hop_run = 1'b0;
      end
    end
  end
  assign chain_start_o = hop_run && (hop_cnt == 3'h1);

  // ****************************************************************
  // conversion sequence
  // ****************************************************************
  typedef enum logic [1:0] {CCS_IDLE, CCS_ACQ, CCS_CONV} ccs_state_e;
  ccs_state_e  state, next_state;
  logic [3:0]  chan, next_chan;
  logic [6:0]  tmr, next_tmr;
  logic [3:0]  rep, next_rep;
  logic [14:0] acc, next_acc;
  ccs_pkg::ccs_result_s next_result;
  logic        next_result_valid;
  logic [11:0] avg_val;

  assign avg_val = 12'((acc + 15'(adc_data_i)) >> avg_f);

  always_comb begin
    next_state        = state;
    next_chan         = chan;
    next_tmr          = tmr;
    next_rep          = rep;
    next_acc          = acc;
    next_results      = results;
    next_result       = result_o;
    next_result_valid = 1'b0;
    adc_start_o       = 1'b0;
    unique case (state)
      CCS_IDLE: begin
        next_chan = (sel_f == ccs_pkg::SEL_SELFTEST) ? 4'hC : 4'h0;
        if (start_evt) begin
          next_state = CCS_CONV; // first input already held
          next_tmr   = 7'(ccs_pkg::CONV_CYC);
          next_rep   = 4'h0;
          next_acc   = 15'h0000;
          adc_start_o = 1'b1;
        end
      end
      CCS_ACQ: begin
        if (tmr <= 7'h1) begin
          next_state  = CCS_CONV;
          adc_start_o = 1'b1;
        end else begin
          next_tmr = tmr - 7'h1;
        end
      end
      CCS_CONV: begin
        if (adc_valid_i) begin
          next_tmr = acq_cycles(acq_f);
          if (rep != 4'((4'h1 << avg_f) - 4'h1)) begin
            next_acc   = acc + 15'(adc_data_i);
            next_rep   = rep + 4'h1;
            next_state = CCS_ACQ;
          end else begin
            next_results[chan] = avg_val;
            next_result.chan   = chan;
            next_result.data   = avg_val;
            next_result.alert_en = !((chan == 4'hA && alert_cfg[1]) ||
                                     (chan == 4'h8 && alert_cfg[0]));
            next_result_valid  = 1'b1;
            next_rep = 4'h0;
            next_acc = 15'h0000;
            if (chan < 4'hB && channel_selected(sel_f, chan + 4'h1)) begin
              next_chan  = chan + 4'h1;
              next_state = CCS_ACQ;
            end else if (chan < 4'hA && channel_selected(sel_f, chan + 4'h2)) begin
              next_chan  = chan + 4'h2;
              next_state = CCS_ACQ;
            end else begin
              next_chan  = 4'h0; // back to cell one
              next_state = CCS_IDLE;
            end
          end
        end
      end
    endcase
  end

  assign adc_chan_o    = chan;
  assign adc_bandgap_o = (chan == ccs_pkg::SELFTEST_CH[3:0]);
  assign busy_o        = (state != CCS_IDLE);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      control        <= ccs_pkg::CONTROL_RST;
      alert_cfg      <= ccs_pkg::ALERT_RST;
      rd_ack         <= 1'b0;
      rdata          <= 32'h0000_0000;
      cs_prev        <= 1'b1;
      pin_prev       <= 1'b1;
      hop_cnt        <= 3'h0;
      hop_run        <= 1'b0;
      state          <= CCS_IDLE;
      chan           <= 4'h0;
      tmr            <= 7'h00;
      rep            <= 4'h0;
      acc            <= 15'h0000;
      result_o       <= '0;
      result_valid_o <= 1'b0;
      for (int i = 0; i < ccs_pkg::NUM_CH; i++) results[i] <= 12'h000;
    end else begin
      control        <= next_control;
      alert_cfg      <= next_alert_cfg;
      rd_ack         <= next_rd_ack;
      rdata          <= next_rdata;
      cs_prev        <= next_cs_prev;
      pin_prev       <= next_pin_prev;
      hop_cnt        <= next_hop_cnt;
      hop_run        <= next_hop_run;
      state          <= next_state;
      chan           <= next_chan;
      tmr            <= next_tmr;
      rep            <= next_rep;
      acc            <= next_acc;
      result_o       <= next_result;
      result_valid_o <= next_result_valid;
      results        <= next_results;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_start_relay: assert property (@(posedge clk_i) disable iff (srst_i)
    relay_evt && !hop_run |-> ##(ccs_pkg::HOP_CYC) chain_start_o)
    else $error("chain start not relayed after hop delay");
  a_pin_start: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(conversion_start_pin_n_i) && state == CCS_IDLE |=> state == CCS_CONV)
    else $error("pin start ignored");
  a_cs_start: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(cs_n_i) && state == CCS_IDLE |=> busy_o)
    else $error("chip select start ignored");
  a_volt_only: assert property (@(posedge clk_i) disable iff (srst_i)
    adc_start_o && sel_f == ccs_pkg::SEL_VOLT |-> chan < 4'h6)
    else $error("temperature converted in voltage mode");
  a_odd_temps: assert property (@(posedge clk_i) disable iff (srst_i)
    adc_start_o && sel_f == ccs_pkg::SEL_ODD |-> chan != 4'h7 && chan != 4'h9 && chan != 4'hB)
    else $error("even temperature converted");
  a_mask_t5: assert property (@(posedge clk_i) disable iff (srst_i)
    result_valid_o && result_o.chan == 4'hA && alert_cfg[1] |-> !result_o.alert_en)
    else $error("masked temperature reached alert");
  a_selftest_alert: assert property (@(posedge clk_i) disable iff (srst_i)
    result_valid_o && result_o.chan == 4'hC |-> result_o.alert_en)
    else $error("self-test result kept from alert path");
  a_return_cell1: assert property (@(posedge clk_i) disable iff (srst_i)
    state == CCS_CONV && next_state == CCS_IDLE |=> chan == 4'h0 || sel_f == ccs_pkg::SEL_SELFTEST)
    else $error("mux not returned to cell one");
  a_acq_time: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(state == CCS_ACQ) |-> tmr == acq_cycles(acq_f))
    else $error("acquisition time wrong");
  a_read_ans: assert property (@(posedge clk_i) disable iff (srst_i)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered in one cycle");

endmodule

// File: verification/ccs_adc_model.sv
/*
  behavioural converter for the chain conversion sequencer: answers each
  hold-and-convert pulse with a valid pulse at the end of one conversion slot.
  assumes one clock, start sampled on the rising edge, data repeat-coded.
*/
`timescale 1ns/1ps

module ccs_adc_model (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  chan_i,
  input  wire logic        busy_i,
  output logic             valid_o,
  output logic [11:0]      data_o
);
  logic [3:0]  last_chan = 4'h0;
  logic [3:0]  rep       = 4'h0;
  logic [3:0]  wait_cnt  = 4'h0;
  logic [11:0] held      = 12'h000;
  logic        pending   = 1'b0;

  initial begin
    valid_o = 1'b0;
    data_o  = 12'hA5A;
  end

  // ****************************************************************
  // conversion answer
  // ****************************************************************
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    // data is only valid with the pulse, so it toggles otherwise
    data_o  <= ~data_o;
    if (srst_i) begin
      pending = 1'b0;
    end else if (start_i === 1'b1) begin
      // repeats of one channel count up so averaging is visible
      rep       = (busy_i === 1'b1 && chan_i == last_chan) ? rep + 4'h1 : 4'h0;
      last_chan = chan_i;
      held      = {chan_i, 8'h10} + {8'h00, rep};
      // valid lands so the conversion phase lasts exactly one slot
      wait_cnt  = 4'(ccs_pkg::CONV_CYC - 1);
      pending   = 1'b1;
    end else if (pending) begin
      wait_cnt = wait_cnt - 4'h1;
      if (wait_cnt == 4'h0) begin
        pending = 1'b0;
        valid_o <= 1'b1;
        data_o  <= held;
      end
    end
  end
endmodule

// File: verification/tb_chain_conversion_sequencer.sv
/*
  self-checking bench for the chain conversion sequencer: runs sequences
  for every selection code, checks results, relay timing and readback.
  assumes the converter model beside it and a 25 MHz clock.
*/
`timescale 1ns/1ps

module tb_chain_conversion_sequencer;
  logic                 clk_i, srst_i, start_pin_n, cs_n, chain_in, adc_valid;
  logic [11:0]          adc_data;
  logic                 chain_start_o, adc_start_o, adc_bandgap_o, term_en, busy_o;
  logic [3:0]           adc_chan_o;
  ccs_pkg::ccs_result_s result_o;
  logic                 result_valid_o, avs_read, avs_write, avs_waitrequest;
  logic [7:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata;
  ccs_pkg::ccs_result_s exp_q[$];
  int                   err_count  = 0;
  int                   num_checks = 0;

  ccs_sequencer dut (.clk_i(clk_i), .srst_i(srst_i), .conversion_start_pin_n_i(start_pin_n),
    .cs_n_i(cs_n), .chain_start_i(chain_in), .chain_start_o(chain_start_o),
    .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o), .adc_bandgap_o(adc_bandgap_o),
    .adc_valid_i(adc_valid), .adc_data_i(adc_data), .thermistor_termination_en_o(term_en),
    .result_o(result_o), .result_valid_o(result_valid_o), .busy_o(busy_o),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  ccs_adc_model u_adc (.clk_i(clk_i), .srst_i(srst_i), .start_i(adc_start_o),
    .chan_i(adc_chan_o), .busy_i(busy_o), .valid_o(adc_valid), .data_o(adc_data));

  // ****************************************************************
  // compare and bus tasks
  // ****************************************************************
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_r(input ccs_pkg::ccs_result_s got, input ccs_pkg::ccs_result_s exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected result at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************************
  // one conversion sequence
  // ****************************************************************
  task automatic run_seq(input logic [1:0] sel, input logic [1:0] avg, input logic [1:0] acq,
                         input logic [1:0] mask, input int src);
    logic [31:0]          q;
    logic [15:0]          ctl;
    ccs_pkg::ccs_result_s r;
    logic [3:0]           chans[$];
    int                   n, hop, len, nrep, acq_cyc, exp_len;
    // termination only with the longest acquisition
    ctl = {sel, 2'b01, 1'b0, avg, 2'b00, acq, 1'b0, (acq == 2'h3), 3'b000};
    bus(1'b1, ccs_pkg::OFS_CONTROL, {16'h0000, ctl}, q);
    bus(1'b1, ccs_pkg::OFS_ALERT, {30'h0, mask}, q);
    bus(1'b0, ccs_pkg::OFS_CONTROL, 32'h0, q);
    chk_w(q, {16'h0000, ctl});
    chk_w({31'h0, term_en}, {31'h0, ctl[3]});
    if (sel == ccs_pkg::SEL_SELFTEST) begin
      chans.push_back(4'hC);
    end else begin
      for (int i = 0; i < 6; i++) chans.push_back(4'(i));
      for (int i = 0; i < 6; i++) begin
        if (sel == ccs_pkg::SEL_ALL || (sel == ccs_pkg::SEL_ODD && i % 2 == 0)) begin
          chans.push_back(4'(6 + i));
        end
      end
    end
    nrep = 1 << avg;
    foreach (chans[i]) begin
      r.chan     = chans[i];
      r.data     = {chans[i], 8'h10} + 12'((nrep * (nrep - 1) / 2) >> avg);
      r.alert_en = !((chans[i] == 4'h8 && mask[0]) || (chans[i] == 4'hA && mask[1]));
      exp_q.push_back(r);
    end
    if (src == 3) begin
      bus(1'b1, ccs_pkg::OFS_COMMAND, 32'h0000_0003, q);
    end else begin
      case (src)
        0: start_pin_n <= 1'b0;
        1: cs_n <= 1'b0;
        default: chain_in <= 1'b1;
      endcase
      @(posedge clk_i);
      start_pin_n <= 1'b1;
      cs_n        <= 1'b1;
      chain_in    <= 1'b0;
      if (src == 1) @(posedge clk_i);
    end
    hop = 0;
    // command start: one busy cycle already passed inside the bus task
    len = (src == 3) ? 1 : 0;
    for (n = (src == 3) ? 2 : 1; n < 20000; n++) begin
      @(posedge clk_i);
      if (adc_start_o === 1'b1) begin
        chk_w({31'h0, adc_bandgap_o}, {31'h0, sel == ccs_pkg::SEL_SELFTEST});
      end
      if (chain_start_o === 1'b1 && hop == 0) hop = n;
      if (busy_o === 1'b1) len++;
      if (busy_o !== 1'b1 && n > 2) break;
    end
    acq_cyc = ccs_pkg::ACQ_STEP_CYC * (acq + 1);
    exp_len = chans.size() * nrep * (acq_cyc + ccs_pkg::CONV_CYC) - acq_cyc;
    chk_w(32'(hop), 32'(ccs_pkg::HOP_CYC));
    chk_w({31'h0, (len + 3 >= exp_len && len <= exp_len + 3)}, 32'h1);
    repeat (3) @(posedge clk_i);
    chk_w(32'(exp_q.size()), 32'h0);
    foreach (chans[i]) begin
      bus(1'b0, ccs_pkg::OFS_RESULT0 + {2'b00, chans[i], 2'b00}, 32'h0, q);
      chk_w(q, {20'h0, {chans[i], 8'h10} + 12'((nrep * (nrep - 1) / 2) >> avg)});
    end
    $display("test sel %0d avg %0d acq %0d src %0d done", sel, avg, acq, src);
  endtask

  // ****************************************************************
  // result watcher
  // ****************************************************************
  always @(posedge clk_i) begin
    if (result_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("unexpected extra result at %0t: got %h expected %h", $time, result_o, 17'h0);
      end else begin
        chk_r(result_o, exp_q.pop_front());
      end
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    #(40 * 60000);
    err_count++;
    conclude();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] q;
    srst_i = 1'b1;
    start_pin_n = 1'b1;
    cs_n = 1'b1;
    chain_in = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    void'($urandom(40));
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, ccs_pkg::OFS_CONTROL, 32'h0, q);
    chk_w(q, {16'h0000, ccs_pkg::CONTROL_RST});
    bus(1'b0, ccs_pkg::OFS_ALERT, 32'h0, q);
    chk_w(q, {30'h0, ccs_pkg::ALERT_RST});
    bus(1'b0, 8'h30, 32'h0, q);
    chk_w(q, 32'h0);
    $display("test reset values done");
    run_seq(ccs_pkg::SEL_ALL, 2'h0, 2'h0, 2'h0, 0);
    run_seq(ccs_pkg::SEL_ODD, 2'h1, 2'h1, 2'h3, 1);
    run_seq(ccs_pkg::SEL_VOLT, 2'h3, 2'h3, 2'h1, 2);
    run_seq(ccs_pkg::SEL_SELFTEST, 2'h2, 2'h2, 2'h2, 3);
    run_seq(2'($urandom % 4), 2'($urandom % 4), 2'($urandom % 4), 2'($urandom % 4),
            int'($urandom % 4));
    conclude();
  end
endmodule
